// ==== rtl/power_save_map.svh ====
`ifndef POWER_SAVE_MAP_SVH
`define POWER_SAVE_MAP_SVH
`define PS_OPERAND_SLEEP 1'h0
`define PS_OPERAND_IDLE 1'h1
`define PS_REG_BIT_KEEP 8
`define PS_RESET_CONTROL_REGISTER_RESET 16'h0100
`define PS_REG_WAKE_US 190
`define PS_CLOCK_MHZ 40
`define PS_REG_WAKE_CYCLES (`PS_REG_WAKE_US * `PS_CLOCK_MHZ)
`define PS_OSC_RESET 3'h0
`endif

// ==== rtl/power_save_pkg.sv ====
`default_nettype none
package power_save_pkg;
  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_IDLE = 3'b001,
    ST_SLEEP = 3'b010,
    ST_REG_WAKE = 3'b011,
    ST_OSC_WAKE = 3'b100
  } state_e;
  typedef struct packed {
    logic cpu_clock_on;
    logic periph_clock_on;
    logic osc_on;
    logic regulator_on;
    logic fail_monitor_on;
    logic low_power_rc_clock_on;
  } gate_s;
endpackage : power_save_pkg
`default_nettype wire

// ==== rtl/sleep_idle_power_control.sv ====
`include "power_save_map.svh"
`default_nettype none
module sleep_idle_power_control #(
  parameter int OSC_W = 3,
  parameter int REG_WAKE_CYCLES = `PS_REG_WAKE_CYCLES,
  parameter int OSC_START_CYCLES = 16
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic i_power_save_instruction,
  input wire logic i_power_save_operand,
  input wire logic [15:0] i_irq_pending,
  input wire logic [15:0] i_irq_enable,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_reset_control_register_write,
  input wire logic i_regulator_in_sleep_keep,
  input wire logic i_osc_lock,
  input wire logic i_new_oscillator_select_write,
  input wire logic [OSC_W-1:0] i_new_oscillator_select,
  output logic O_CPU_CLOCK_ON,
  output logic O_PERIPH_CLOCK_ON,
  output logic O_OSC_ON,
  output logic O_REGULATOR_ON,
  output logic O_FAIL_MONITOR_ON,
  output logic O_LOW_POWER_RC_CLOCK_ON,
  output logic O_CN_EXT_ON,
  output logic O_WDT_CLEAR,
  output logic O_SLEEPING,
  output logic O_IDLING,
  output logic O_WAKE,
  output logic [OSC_W-1:0] O_OSC_SELECT
);
  power_save_pkg::state_e state;
  power_save_pkg::state_e next_state;
  power_save_pkg::gate_s next_gate;
  logic [OSC_W-1:0] osc_select;
  logic [OSC_W-1:0] sleep_osc;
  logic regulator_keep;
  logic [31:0] wait_count;
  logic wake_event;
  logic enter_sleep;
  logic enter_idle;

  // Keep bit reset value is taken from the reset control word
  localparam logic [15:0] RESET_CONTROL_REGISTER_RESET = `PS_RESET_CONTROL_REGISTER_RESET;

  // Pending must stand until wake; a pulse between edges is lost
  function automatic logic irq_wake(input logic [15:0] pend, input logic [15:0] en);
    irq_wake = |(pend & en);
  endfunction : irq_wake

  // Wait counter preload: a wait of n cycles stores n-1
  function automatic logic [31:0] load_count(input int cycles);
    load_count = 32'(cycles - 1);
  endfunction : load_count

  function automatic logic is_asleep(input power_save_pkg::state_e s);
    is_asleep = (s == power_save_pkg::ST_SLEEP) || (s == power_save_pkg::ST_REG_WAKE)
                || (s == power_save_pkg::ST_OSC_WAKE);
  endfunction : is_asleep

  // Reset itself is the wake path for resets: it forces ST_RUN
  assign wake_event = irq_wake(i_irq_pending, i_irq_enable) | i_wdt_timeout;
  // Instruction outside run is ignored; the core is halted then anyway
  assign enter_sleep = (state == power_save_pkg::ST_RUN) && i_power_save_instruction
                       && (i_power_save_operand == `PS_OPERAND_SLEEP);
  assign enter_idle = (state == power_save_pkg::ST_RUN) && i_power_save_instruction
                      && (i_power_save_operand == `PS_OPERAND_IDLE);

  always_comb
  begin
    next_state = state;
    case (state)
      power_save_pkg::ST_RUN:
      begin
        if (enter_sleep)
          next_state = power_save_pkg::ST_SLEEP;
        else if (enter_idle)
          next_state = power_save_pkg::ST_IDLE;
      end
      power_save_pkg::ST_IDLE:
      begin
        if (wake_event)
          next_state = power_save_pkg::ST_RUN;
      end
      power_save_pkg::ST_SLEEP:
      begin
        // Regulator off means a long ramp before the oscillator restarts
        if (wake_event)
          next_state = regulator_keep ? power_save_pkg::ST_OSC_WAKE
                                      : power_save_pkg::ST_REG_WAKE;
      end
      power_save_pkg::ST_REG_WAKE:
      begin
        if (wait_count == 32'h0)
          next_state = power_save_pkg::ST_OSC_WAKE;
      end
      power_save_pkg::ST_OSC_WAKE:
      begin
        if (wait_count == 32'h0)
          next_state = power_save_pkg::ST_RUN;
      end
      default:
        next_state = power_save_pkg::ST_RUN;
    endcase
  end

  // Low-power RC follows watchdog enable in every state
  always_comb
  begin
    next_gate = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, i_wdt_enable};
    case (next_state)
      power_save_pkg::ST_IDLE:
        next_gate.cpu_clock_on = 1'b0;
      power_save_pkg::ST_SLEEP, power_save_pkg::ST_REG_WAKE:
      begin
        next_gate.cpu_clock_on = 1'b0;
        next_gate.periph_clock_on = 1'b0;
        next_gate.osc_on = 1'b0;
        next_gate.fail_monitor_on = 1'b0;
        next_gate.regulator_on = regulator_keep | (next_state == power_save_pkg::ST_REG_WAKE);
        next_gate.low_power_rc_clock_on = i_wdt_enable;
      end
      power_save_pkg::ST_OSC_WAKE:
      begin
        // Oscillator restarting; clocks stay gated until it settles
        next_gate.cpu_clock_on = 1'b0;
        next_gate.periph_clock_on = 1'b0;
        next_gate.fail_monitor_on = 1'b0;
      end
      default:
        next_gate.low_power_rc_clock_on = i_wdt_enable;
    endcase
  end

  // Any reset lands in run: that is the reset wake path
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      state <= power_save_pkg::ST_RUN;
    else
      state <= next_state;
  end

  // One counter serves both wake phases; they never overlap
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      wait_count <= 32'h0;
    else if (state == power_save_pkg::ST_SLEEP && next_state == power_save_pkg::ST_REG_WAKE)
      wait_count <= load_count(REG_WAKE_CYCLES);
    else if (next_state == power_save_pkg::ST_OSC_WAKE && state != power_save_pkg::ST_OSC_WAKE)
      wait_count <= load_count(OSC_START_CYCLES);
    else if (wait_count != 32'h0)
      wait_count <= wait_count - 32'h1;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      regulator_keep <= RESET_CONTROL_REGISTER_RESET[`PS_REG_BIT_KEEP]; // Resets set, so regulator stays on
    else if (i_reset_control_register_write)
      regulator_keep <= i_regulator_in_sleep_keep;
  end

  // Writes outside run are dropped so the restored source stays valid
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      osc_select <= OSC_W'(`PS_OSC_RESET);
    else if (i_new_oscillator_select_write && !i_osc_lock && state == power_save_pkg::ST_RUN)
      osc_select <= i_new_oscillator_select;
  end

  // Clock source captured at Sleep entry, restored on wake
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      sleep_osc <= OSC_W'(`PS_OSC_RESET);
    else if (enter_sleep)
      sleep_osc <= osc_select;
  end

  // Gates are decoded from the next state so they switch with the state
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_CPU_CLOCK_ON <= 1'b1;
    else
      O_CPU_CLOCK_ON <= next_gate.cpu_clock_on;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_PERIPH_CLOCK_ON <= 1'b1;
    else
      O_PERIPH_CLOCK_ON <= next_gate.periph_clock_on;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_OSC_ON <= 1'b1;
    else
      O_OSC_ON <= next_gate.osc_on;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_REGULATOR_ON <= 1'b1;
    else
      O_REGULATOR_ON <= next_gate.regulator_on;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_FAIL_MONITOR_ON <= 1'b1;
    else
      O_FAIL_MONITOR_ON <= next_gate.fail_monitor_on;
  end

  // Off in reset; the watchdog enable brings it up one cycle later
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_LOW_POWER_RC_CLOCK_ON <= 1'b0;
    else
      O_LOW_POWER_RC_CLOCK_ON <= next_gate.low_power_rc_clock_on;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_WDT_CLEAR <= 1'b0;
    else
      O_WDT_CLEAR <= enter_sleep && i_wdt_enable;
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_WAKE <= 1'b0;
    else
      O_WAKE <= (state != power_save_pkg::ST_RUN) && (next_state == power_save_pkg::ST_RUN);
  end

  // Still flagged asleep while the regulator and oscillator ramp
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_SLEEPING <= 1'b0;
    else
      O_SLEEPING <= is_asleep(next_state);
  end

  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_IDLING <= 1'b0;
    else
      O_IDLING <= (next_state == power_save_pkg::ST_IDLE);
  end

  // Change notification and external-clock peripherals never gated here
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_CN_EXT_ON <= 1'b1;
    else
      O_CN_EXT_ON <= 1'b1;
  end

  // Source lags the select write by two cycles
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RESETN)
      O_OSC_SELECT <= OSC_W'(`PS_OSC_RESET);
    else
      O_OSC_SELECT <= (state == power_save_pkg::ST_OSC_WAKE) ? sleep_osc : osc_select;
  end
endmodule : sleep_idle_power_control
`default_nettype wire

// ==== testbench/power_save_sva.sv ====
`default_nettype none
module power_save_sva #(
  parameter int OSC_W = 3
) (
  input wire logic I_CLOCK,
  input wire logic I_RESETN,
  input wire logic i_power_save_instruction,
  input wire logic i_power_save_operand,
  input wire logic [15:0] i_irq_pending,
  input wire logic [15:0] i_irq_enable,
  input wire logic i_wdt_enable,
  input wire logic i_wdt_timeout,
  input wire logic i_osc_lock,
  input wire logic O_CPU_CLOCK_ON,
  input wire logic O_PERIPH_CLOCK_ON,
  input wire logic O_OSC_ON,
  input wire logic O_REGULATOR_ON,
  input wire logic O_FAIL_MONITOR_ON,
  input wire logic O_WDT_CLEAR,
  input wire logic O_SLEEPING,
  input wire logic O_IDLING,
  input wire logic O_WAKE,
  input wire logic [OSC_W-1:0] O_OSC_SELECT
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (!I_RESETN);
  wire logic run = !O_SLEEPING && !O_IDLING;
  wire logic go = run && i_power_save_instruction;
  wire logic ev = (|(i_irq_pending & i_irq_enable)) || i_wdt_timeout;
  a_sleep_entry: assert property (
    go && !i_power_save_operand |=> O_SLEEPING && !O_CPU_CLOCK_ON && !O_PERIPH_CLOCK_ON
    && !O_OSC_ON) else $error("sleep entry gates wrong");
  a_idle_entry: assert property (
    go && i_power_save_operand |=> O_IDLING && !O_CPU_CLOCK_ON) else $error("idle entry wrong");
  a_idle_keeps: assert property (
    O_IDLING |-> O_PERIPH_CLOCK_ON && O_OSC_ON) else $error("idle lost a clock");
  a_idle_wake: assert property (
    O_IDLING && ev |=> O_WAKE && O_CPU_CLOCK_ON && O_OSC_ON) else $error("idle wake late");
  a_sleep_wake: assert property (
    O_SLEEPING && ev |-> ##[1:40] O_WAKE) else $error("sleep wake missing");
  a_masked_stay: assert property (
    O_SLEEPING && !O_OSC_ON && !O_REGULATOR_ON && !ev |=> O_SLEEPING && !O_OSC_ON)
    else $error("sleep left without cause");
  a_monitor_off: assert property (
    O_SLEEPING && !O_OSC_ON |-> !O_FAIL_MONITOR_ON) else $error("monitor on in sleep");
  a_wdt_clear: assert property (
    go && !i_power_save_operand |=> O_WDT_CLEAR == $past(i_wdt_enable)) else $error("wdt clear");
  a_osc_hold: assert property (
    I_RESETN && (i_osc_lock || !run) |=> $stable(O_OSC_SELECT))
    else $error("clock source changed");
  c_sleep: cover property (O_SLEEPING ##1 O_WAKE);
  c_idle: cover property (O_IDLING ##1 O_WAKE);
  c_masked: cover property (O_SLEEPING && (|i_irq_pending) && !ev);
endmodule : power_save_sva
bind sleep_idle_power_control power_save_sva #(.OSC_W(OSC_W)) checker_i (.*);
`default_nettype wire

// ==== testbench/irq_source_model.sv ====
`default_nettype none
module irq_source_model (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic i_halted,
  input wire logic i_wake,
  input wire logic [3:0] i_line,
  output logic [15:0] o_pending
);
  logic [2:0] delay;
  // Flag rises a few cycles into the halt and stays until the wake pulse clears it
  always_ff @(posedge clk)
  begin
    if (!reset_n || i_wake)
    begin
      delay <= 3'h0;
      o_pending <= 16'h0000;
    end
    else if (i_halted && delay != 3'h4)
      delay <= delay + 3'h1;
    else if (i_halted)
      o_pending <= 16'h0001 << i_line;
  end
endmodule : irq_source_model
`default_nettype wire

// ==== testbench/test_sleep_idle_power_control.sv ====
`default_nettype none
module test_sleep_idle_power_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLOCK, I_RESETN, i_power_save_instruction, i_power_save_operand, i_wdt_enable;
  logic i_wdt_timeout, i_reset_control_register_write, i_regulator_in_sleep_keep, i_osc_lock;
  logic i_new_oscillator_select_write, O_CPU_CLOCK_ON, O_PERIPH_CLOCK_ON, O_OSC_ON;
  logic O_REGULATOR_ON, O_FAIL_MONITOR_ON, O_LOW_POWER_RC_CLOCK_ON, O_CN_EXT_ON, O_WDT_CLEAR;
  logic O_SLEEPING, O_IDLING, O_WAKE;
  logic [2:0] i_new_oscillator_select, O_OSC_SELECT;
  logic [15:0] i_irq_pending, i_irq_enable;
  logic [3:0] line;
  int errors, checks, n0, n1;
  sleep_idle_power_control #(.REG_WAKE_CYCLES(8), .OSC_START_CYCLES(2)) DUT (.*);
  irq_source_model source (.clk(I_CLOCK), .reset_n(I_RESETN), .i_halted(O_SLEEPING || O_IDLING),
    .i_wake(O_WAKE), .i_line(line), .o_pending(i_irq_pending));
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  task automatic execute(input logic op);
    @(posedge I_CLOCK);
    i_power_save_instruction <= 1'b1;
    i_power_save_operand <= op;
    @(posedge I_CLOCK);
    i_power_save_instruction <= 1'b0;
    @(negedge I_CLOCK);
  endtask : execute
  task automatic wait_wake(output int n);
    n = 0;
    while (O_WAKE !== 1'b1 && n < 200)
    begin
      @(negedge I_CLOCK);
      n++;
    end
    if (O_WAKE !== 1'b1)
    begin
      errors++;
      tally_and_finish();
    end
  endtask : wait_wake
  task automatic t_osc(input logic lock, input logic [2:0] exp);
    @(posedge I_CLOCK);
    i_osc_lock <= lock;
    i_new_oscillator_select_write <= 1'b1;
    i_new_oscillator_select <= 3'h5;
    @(posedge I_CLOCK);
    i_new_oscillator_select_write <= 1'b0;
    repeat (2) @(negedge I_CLOCK);
    check("source", O_OSC_SELECT, exp);
  endtask : t_osc
  task automatic t_idle;
    @(posedge I_CLOCK);
    i_irq_enable <= 16'h0001 << line;
    execute(1'b1);
    check("idle", {O_IDLING, O_CPU_CLOCK_ON, O_PERIPH_CLOCK_ON, O_OSC_ON}, 4'hb);
    wait_wake(n0);
    check("idle wake", {O_IDLING, O_CPU_CLOCK_ON, O_OSC_ON}, 3'h3);
  endtask : t_idle
  task automatic t_sleep(input logic keep, input logic wdt, output int n);
    @(posedge I_CLOCK);
    i_reset_control_register_write <= 1'b1;
    i_regulator_in_sleep_keep <= keep;
    i_wdt_enable <= wdt;
    i_irq_enable <= 16'h0000;
    @(posedge I_CLOCK);
    i_reset_control_register_write <= 1'b0;
    execute(1'b0);
    check("sleep", {O_SLEEPING, O_CPU_CLOCK_ON, O_PERIPH_CLOCK_ON, O_OSC_ON}, 4'h8);
    check("monitor cn", {O_FAIL_MONITOR_ON, O_CN_EXT_ON}, 2'h1);
    check("regulator", O_REGULATOR_ON, keep);
    check("low_power_rc_clock clear", {O_LOW_POWER_RC_CLOCK_ON, O_WDT_CLEAR}, {wdt, wdt});
    repeat (20) @(negedge I_CLOCK);
    check("masked", O_SLEEPING, 1'b1);
    @(posedge I_CLOCK);
    i_irq_enable <= 16'h0001 << line;
    wait_wake(n);
    check("resume", O_OSC_SELECT, 3'h5);
  endtask : t_sleep
  task automatic t_other_wakes;
    @(posedge I_CLOCK);
    i_irq_enable <= 16'h0000;
    execute(1'b0);
    @(posedge I_CLOCK);
    i_wdt_timeout <= 1'b1;
    wait_wake(n0);
    check("wdt wake", O_SLEEPING, 1'b0);
    @(posedge I_CLOCK);
    i_wdt_timeout <= 1'b0;
    execute(1'b1);
    @(posedge I_CLOCK);
    I_RESETN <= 1'b0;
    @(posedge I_CLOCK);
    I_RESETN <= 1'b1;
    @(negedge I_CLOCK);
    check("reset wake", {O_IDLING, O_CPU_CLOCK_ON}, 2'h1);
  endtask : t_other_wakes
  initial
  begin
    I_CLOCK = 1'b0;
    forever #12.5 I_CLOCK = ~I_CLOCK;
  end
  initial
  begin
    {I_RESETN, i_power_save_instruction, i_power_save_operand, i_wdt_enable} = 4'h0;
    {i_wdt_timeout, i_reset_control_register_write, i_osc_lock, i_new_oscillator_select_write} = 4'h0;
    i_regulator_in_sleep_keep = 1'b1;
    i_new_oscillator_select = 3'h0;
    i_irq_enable = 16'h0000;
    line = 4'h3;
    errors = 0;
    checks = 0;
    repeat (10) @(posedge I_CLOCK);
    I_RESETN <= 1'b1;
    @(negedge I_CLOCK);
    check("reset", {O_CPU_CLOCK_ON, O_OSC_ON, O_LOW_POWER_RC_CLOCK_ON, O_SLEEPING, O_WAKE}, 5'h18);
    t_osc(1'b1, 3'h0);
    t_osc(1'b0, 3'h5);
    t_idle();
    t_sleep(1'b1, 1'b1, n1);
    t_sleep(1'b0, 1'b0, n0);
    check("regulator delay", 16'(n0 - n1), 16'h0008);
    t_other_wakes();
    tally_and_finish();
  end
endmodule : test_sleep_idle_power_control
`default_nettype wire
